// ==== fieldbus_node_config.sv ====
/*
 * Fieldbus node configuration: switch decoding, link rate and autobaud
 * settings, and the actual / temporary-required / required configuration
 * memories with save switch, network commands and mismatch indication.
 * Assumes an APB master on MCLK, an external non-volatile store that holds
 * NV_OUT when NV_WE pulses and presents it on NV_IN from power-up, and a
 * module bus that supplies the current station configuration on CUR_CFG.
 */
// Our own choices: the APB register port and the address map.
//
// Functional notes
// - node address is the weighted sum of six switches; default address 63.
// - rate switches 00=125k, low=1 250k, high=1 500k, 11=autobaud.
// - autobaud enable writes accepted only while rate switches read 11.
// - with switches at 11 the network may set the bit rate attribute.
// - other switch settings force the fixed rate; network values ignored.
// - new address, rate or autobaud values take effect after power cycle.
// - save switch off-on-off stores current config into all three memories.
// - termination resistor takes the switch just before the save switch once, at power-up.
// - tool-written configuration lands only in the temporary-required memory.
// - commit command copies temporary-required into required memory.
// - module-bus indicator flashes while temporary-required differs from actual.
// - load-current command copies actual into temporary-required and required.
// - restore command copies required back into temporary-required.
// - load-current and restore overwrite pending uncommitted changes.
// - required configuration is kept in non-volatile storage.
// - internal module bus works without node addressing.
`default_nettype none
module fieldbus_node_config #(
	parameter int FLASH_HALF_CYC = node_cfg_pkg::FLASH_HALF_CYC
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire node_cfg_pkg::switch_type SW_PINS,
	input wire logic [node_cfg_pkg::CFG_W-1:0] CUR_CFG,
	input wire node_cfg_pkg::nv_type NV_IN,
	output node_cfg_pkg::nv_type NV_OUT,
	output logic NV_WE,
	output logic [5:0] NODE_ADDR,
	output logic [1:0] BIT_RATE,
	output logic AUTOBAUD_EN,
	output logic TERM_EN,
	output logic GW_LED,
	output logic IOS_LED,
	output logic IRQ
);
	localparam int CW = node_cfg_pkg::CFG_W;
	localparam int IW = node_cfg_pkg::IRQ_W;

	typedef enum logic [1:0] {ST_SETTLE, ST_CAPTURE, ST_RUN} boot_type;

	// synchronised switch pins; only the second stage is used here
	node_cfg_pkg::switch_type sw_sync;
	pin_sync #(.W($bits(node_cfg_pkg::switch_type))) u_sync (
		.clk(MCLK),
		.rst(SYS_RST),
		.d(SW_PINS),
		.q(sw_sync)
	);

	logic flash_tick;
	logic flash_phase;
	blink_gen #(.HALF_CYC(FLASH_HALF_CYC)) u_blink (
		.clk(MCLK),
		.rst(SYS_RST),
		.tick(flash_tick),
		.phase(flash_phase)
	);

	boot_type boot_reg;
	logic [1:0] settle_reg;
	node_cfg_pkg::switch_type held_reg;
	logic [5:0] addr_reg;
	logic [1:0] rate_reg;
	logic autobaud_reg;
	logic term_reg;
	logic nv_auto_reg;
	logic [1:0] nv_rate_reg;
	logic nv_we_reg;
	logic [CW-1:0] actual_reg;
	logic [CW-1:0] temp_reg;
	logic [CW-1:0] req_reg;
	logic save_armed_reg;
	logic save_on_reg;
	logic save_prev_reg;
	logic [3:0] gw_flash_reg;
	logic gw_led_reg;
	logic ios_led_reg;
	logic [IW-1:0] irq_stat_reg;
	logic [IW-1:0] irq_mask_reg;
	logic irq_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	// bus decode
	wire setup_phase = PSEL && !PENABLE;
	wire access_done = PSEL && PENABLE && pready_reg;
	wire wr_done = access_done && PWRITE;
	wire hit_cmd = (PADDR == node_cfg_pkg::CMD_OFFS);
	wire hit_link = (PADDR == node_cfg_pkg::LINK_OFFS);
	wire hit_stat = (PADDR == node_cfg_pkg::STAT_OFFS);
	wire hit_temp = (PADDR == node_cfg_pkg::TEMP_OFFS);
	wire hit_actual = (PADDR == node_cfg_pkg::ACTUAL_OFFS);
	wire hit_req = (PADDR == node_cfg_pkg::REQ_OFFS);
	wire hit_cur = (PADDR == node_cfg_pkg::CURRENT_OFFS);
	wire hit_istat = (PADDR == node_cfg_pkg::IRQ_STAT_OFFS);
	wire hit_imask = (PADDR == node_cfg_pkg::IRQ_MASK_OFFS);
	wire hit_any = hit_cmd | hit_link | hit_stat | hit_temp | hit_actual | hit_req |
		hit_cur | hit_istat | hit_imask;

	// switch-held autobaud position gates network link writes
	wire sw_auto = (held_reg.rate == node_cfg_pkg::SW_AUTOBAUD);
	wire link_ok = sw_auto && boot_reg == ST_RUN;
	wire [1:0] wr_rate = PWDATA[node_cfg_pkg::LINK_RATE_LSB +: 2];
	// unsupported rate codes are refused rather than stored
	wire rate_bad = (wr_rate == node_cfg_pkg::SW_AUTOBAUD);
	// acceptance follows the answer already given in the access cycle, so a
	// write decoded just before run starts is never refused yet stored
	wire link_rej_any = wr_done && hit_link && pslverr_reg;
	wire link_take = wr_done && hit_link && !pslverr_reg;

	// a byte code selects the memory move; unknown codes are refused
	wire cmd_wr = wr_done && hit_cmd;
	wire cmd_commit = cmd_wr && PWDATA[7:0] == node_cfg_pkg::CMD_COMMIT;
	wire cmd_load = cmd_wr && PWDATA[7:0] == node_cfg_pkg::CMD_LOAD_CURRENT;
	wire cmd_restore = cmd_wr && PWDATA[7:0] == node_cfg_pkg::CMD_RESTORE;
	wire temp_wr = wr_done && hit_temp;

	// refusal decode for the setup cycle, answered with the ready pulse
	wire cmd_known = (PWDATA[7:0] == node_cfg_pkg::CMD_COMMIT) ||
		(PWDATA[7:0] == node_cfg_pkg::CMD_LOAD_CURRENT) ||
		(PWDATA[7:0] == node_cfg_pkg::CMD_RESTORE);
	wire cmd_bad = PWRITE && hit_cmd && !cmd_known;
	wire link_bad = PWRITE && hit_link && (!link_ok || rate_bad);
	wire req_bad = !hit_any || link_bad || cmd_bad;

	// save switch sequence off -> on -> off
	wire save_rise = sw_sync.save && !save_prev_reg;
	wire save_fall = !sw_sync.save && save_prev_reg;
	wire save_evt = save_fall && save_on_reg && boot_reg == ST_RUN;

	wire [IW-1:0] irq_evt = {link_rej_any, cmd_restore, cmd_load, cmd_commit, save_evt};
	wire [IW-1:0] irq_w1c = (wr_done && hit_istat) ? PWDATA[IW-1:0] : '0;
	// restore leaves the required memory untouched, so it needs no store write
	wire nv_dirty = save_evt || cmd_commit || cmd_load || link_take;
	wire mismatch = (temp_reg != actual_reg);

	// status: [5:0] address, [7:6] held rate switches, [9:8] effective rate,
	// [10] autobaud, [11] termination, [12] mismatch
	wire [31:0] stat_word = {19'h0, mismatch, term_reg, autobaud_reg, rate_reg,
		held_reg.rate, addr_reg};
	// pending link settings as they will appear after the next power-up
	wire [31:0] link_word = {29'h0, nv_rate_reg, nv_auto_reg};
	wire [31:0] rd_mux =
		hit_link ? link_word :
		hit_stat ? stat_word :
		hit_temp ? 32'(temp_reg) :
		hit_actual ? 32'(actual_reg) :
		hit_req ? 32'(req_reg) :
		hit_cur ? 32'(CUR_CFG) :
		hit_istat ? 32'(irq_stat_reg) :
		hit_imask ? 32'(irq_mask_reg) : 32'h0;

	// APB slave: answer is prepared in setup, offered in the first access cycle
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0;
		end else begin
			pready_reg <= setup_phase;
			pslverr_reg <= setup_phase && req_bad;
			prdata_reg <= (setup_phase && !PWRITE) ? rd_mux : 32'h0;
		end
	end

	// switches settle through the synchroniser, then are captured once
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			boot_reg <= ST_SETTLE;
			settle_reg <= 2'h0;
		end else begin
			case (boot_reg)
				ST_SETTLE: begin
					settle_reg <= settle_reg + 2'h1;
					if (settle_reg == node_cfg_pkg::SETTLE_CYC)
						boot_reg <= ST_CAPTURE;
				end
				ST_CAPTURE: boot_reg <= ST_RUN;
				ST_RUN: boot_reg <= ST_RUN;
				default: boot_reg <= ST_SETTLE;
			endcase
		end
	end

	// effective settings are taken at capture and never change until reset
	wire [1:0] eff_rate = (sw_sync.rate == node_cfg_pkg::SW_AUTOBAUD) ?
		NV_IN.rate : sw_sync.rate;
	wire eff_auto = (sw_sync.rate == node_cfg_pkg::SW_AUTOBAUD) && NV_IN.autobaud;

	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			held_reg <= '0;
			addr_reg <= node_cfg_pkg::DEFAULT_ADDR;
			rate_reg <= node_cfg_pkg::RATE_125K;
			autobaud_reg <= 1'b0;
			term_reg <= 1'b0;
		end else if (boot_reg == ST_CAPTURE) begin
			held_reg <= sw_sync;
			addr_reg <= sw_sync.addr;
			rate_reg <= eff_rate;
			autobaud_reg <= eff_auto;
			term_reg <= sw_sync.term;
		end
	end

	// pending link settings: stored for the next power cycle only
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			nv_auto_reg <= 1'b0;
			nv_rate_reg <= node_cfg_pkg::RATE_125K;
		end else if (boot_reg == ST_CAPTURE) begin
			nv_auto_reg <= NV_IN.autobaud;
			nv_rate_reg <= NV_IN.rate;
		end else if (link_take) begin
			nv_auto_reg <= PWDATA[node_cfg_pkg::LINK_AUTOBAUD_BIT];
			nv_rate_reg <= wr_rate;
		end
	end

	// configuration memories; the save switch outranks a same-cycle command
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			actual_reg <= '0;
			temp_reg <= '0;
			req_reg <= '0;
		end else if (boot_reg == ST_CAPTURE) begin
			actual_reg <= NV_IN.required;
			temp_reg <= NV_IN.required;
			req_reg <= NV_IN.required;
		end else if (save_evt) begin
			actual_reg <= CUR_CFG;
			temp_reg <= CUR_CFG;
			req_reg <= CUR_CFG;
		end else if (cmd_load) begin
			temp_reg <= actual_reg;
			req_reg <= actual_reg;
		end else if (cmd_restore) begin
			temp_reg <= req_reg;
		end else if (cmd_commit) begin
			req_reg <= temp_reg;
		end else if (temp_wr) begin
			temp_reg <= PWDATA[CW-1:0];
		end
	end

	// non-volatile image is rewritten whenever its content changes
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			nv_we_reg <= 1'b0;
		else
			nv_we_reg <= nv_dirty;
	end

	// save switch: must be seen off before an on counts, so a switch left on
	// through power-up does not fire a save
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			save_prev_reg <= 1'b0;
			save_armed_reg <= 1'b0;
			save_on_reg <= 1'b0;
		end else if (boot_reg == ST_RUN) begin
			save_prev_reg <= sw_sync.save;
			if (!sw_sync.save && !save_on_reg)
				save_armed_reg <= 1'b1;
			if (save_rise && save_armed_reg)
				save_on_reg <= 1'b1;
			else if (save_fall)
				save_on_reg <= 1'b0;
		end else begin
			save_prev_reg <= sw_sync.save;
		end
	end

	// indicators: gateway steady on, flashing for a burst after a save;
	// module-bus indicator flashes on mismatch, driven with no node address
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			gw_flash_reg <= 4'h0;
			gw_led_reg <= 1'b0;
			ios_led_reg <= 1'b0;
		end else begin
			if (save_evt)
				gw_flash_reg <= node_cfg_pkg::GW_FLASH_TOGGLES;
			else if (flash_tick && gw_flash_reg != 4'h0)
				gw_flash_reg <= gw_flash_reg - 4'h1;
			gw_led_reg <= (boot_reg == ST_RUN) &&
				(gw_flash_reg == 4'h0 || flash_phase);
			ios_led_reg <= (boot_reg == ST_RUN) && (!mismatch || flash_phase);
		end
	end

	// interrupts: sticky events, a new event wins over a same-cycle clear
	// the mask reads back as written; status bits clear by writing ones
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_w1c) | irq_evt;
			if (wr_done && hit_imask)
				irq_mask_reg <= PWDATA[IW-1:0];
			irq_reg <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	assign PRDATA = prdata_reg;
	assign PREADY = pready_reg;
	assign PSLVERR = pslverr_reg;
	assign NV_OUT = '{autobaud: nv_auto_reg, rate: nv_rate_reg, required: req_reg};
	assign NV_WE = nv_we_reg;
	assign NODE_ADDR = addr_reg;
	assign BIT_RATE = rate_reg;
	assign AUTOBAUD_EN = autobaud_reg;
	assign TERM_EN = term_reg;
	assign GW_LED = gw_led_reg;
	assign IOS_LED = ios_led_reg;
	assign IRQ = irq_reg;
endmodule : fieldbus_node_config
`default_nettype wire

// ==== node_cfg_pkg.sv ====
/*
 * Shared constants and types for the fieldbus node configuration block:
 * register map, field positions, reset values, rate codes and command codes.
 * Assumes a single 200 MHz clock and 32-bit APB register access.
 */
`default_nettype none
package node_cfg_pkg;
	localparam int CFG_W = 32;
	localparam int CLK_MHZ = 200;
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
	localparam logic [3:0] GW_FLASH_TOGGLES = 4'h8;
	localparam logic [1:0] SETTLE_CYC = 2'h3;

	localparam logic [7:0] CMD_OFFS = 8'h00;
	localparam logic [7:0] LINK_OFFS = 8'h04;
	localparam logic [7:0] STAT_OFFS = 8'h08;
	localparam logic [7:0] TEMP_OFFS = 8'h0c;
	localparam logic [7:0] ACTUAL_OFFS = 8'h10;
	localparam logic [7:0] REQ_OFFS = 8'h14;
	localparam logic [7:0] CURRENT_OFFS = 8'h18;
	localparam logic [7:0] IRQ_STAT_OFFS = 8'h1c;
	localparam logic [7:0] IRQ_MASK_OFFS = 8'h20;

	localparam logic [7:0] CMD_COMMIT = 8'h01;
	localparam logic [7:0] CMD_LOAD_CURRENT = 8'h02;
	localparam logic [7:0] CMD_RESTORE = 8'h03;

	localparam logic [1:0] RATE_125K = 2'h0;
	localparam logic [1:0] RATE_250K = 2'h1;
	localparam logic [1:0] RATE_500K = 2'h2;
	localparam logic [1:0] SW_AUTOBAUD = 2'h3;
	localparam logic [5:0] DEFAULT_ADDR = 6'h3f;

	localparam int LINK_AUTOBAUD_BIT = 0;
	localparam int LINK_RATE_LSB = 1;
	localparam int IRQ_W = 5;
	localparam int IRQ_SAVE = 0;
	localparam int IRQ_COMMIT = 1;
	localparam int IRQ_LOAD = 2;
	localparam int IRQ_RESTORE = 3;
	localparam int IRQ_REJECT = 4;

	typedef struct packed {
		logic autobaud;
		logic [1:0] rate;
		logic [CFG_W-1:0] required;
	} nv_type;

	typedef struct packed {
		logic [5:0] addr;
		logic [1:0] rate;
		logic term;
		logic save;
	} switch_type;
endpackage : node_cfg_pkg
`default_nettype wire

// ==== pin_sync.sv ====
/*
 * Two flip-flop synchroniser for a bank of slow switch pins.
 * Assumes the pins are quasi-static levels; no pulses shorter than a clock.
 */
`default_nettype none
module pin_sync #(
	parameter int W = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= d;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule : pin_sync
`default_nettype wire

// ==== blink_gen.sv ====
/*
 * Divider producing a one-cycle tick every HALF_CYC clocks and a square wave
 * that toggles on each tick. Free running; indicators gate it as needed.
 */
`default_nettype none
module blink_gen #(
	parameter int HALF_CYC = 50000000
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick,
	output logic phase
);
	logic [31:0] cnt_reg;
	logic tick_reg;
	logic phase_reg;
	wire cnt_done = (cnt_reg == 32'(HALF_CYC - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
			phase_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_done ? '0 : cnt_reg + 32'h1;
			tick_reg <= cnt_done;
			phase_reg <= phase_reg ^ cnt_done;
		end
	end

	assign tick = tick_reg;
	assign phase = phase_reg;
endmodule : blink_gen
`default_nettype wire

// ==== fieldbus_node_config_sva.sv ====
/* checker for the node configuration block: switch capture, held settings,
 * link refusal and commit storage.
 * assumes switch pins stay steady from reset until well after capture. */
`default_nettype none
module node_cfg_chk #(
	parameter int FLASH_HALF_CYC = 4
) (
	input wire logic MCLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire node_cfg_pkg::switch_type SW_PINS,
	input wire node_cfg_pkg::nv_type NV_IN,
	input wire logic NV_WE,
	input wire logic [5:0] NODE_ADDR,
	input wire logic [1:0] BIT_RATE,
	input wire logic AUTOBAUD_EN,
	input wire logic TERM_EN
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt_reg;
	logic acc;
	logic commit;
	assign acc = PSEL && PENABLE && PREADY && PWRITE;
	assign commit = acc && PADDR == node_cfg_pkg::CMD_OFFS && PWDATA[7:0] == 8'h01;
	// edges since release; captured values are visible from count 5 on
	always_ff @(posedge MCLK or posedge SYS_RST) begin
		if (SYS_RST)
			cnt_reg <= 4'h0;
		else if (cnt_reg != 4'hf)
			cnt_reg <= cnt_reg + 4'h1;
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (SYS_RST);
	a_addr_default: assert property ($fell(SYS_RST) |-> $past(NODE_ADDR) == 6'h3f)
		else $error("address not 63 during reset");
	a_addr_capture: assert property (cnt_reg == 4'h6 |-> NODE_ADDR == SW_PINS.addr)
		else $error("address differs from switches");
	a_rate_fixed: assert property (cnt_reg == 4'h6 && SW_PINS.rate != 2'h3
		|-> BIT_RATE == SW_PINS.rate && !AUTOBAUD_EN)
		else $error("fixed rate not taken from switches");
	a_rate_net: assert property (cnt_reg == 4'h6 && SW_PINS.rate == 2'h3
		|-> BIT_RATE == NV_IN.rate && AUTOBAUD_EN == NV_IN.autobaud)
		else $error("network rate not applied");
	a_term_capture: assert property (cnt_reg == 4'h6 |-> TERM_EN == SW_PINS.term)
		else $error("termination differs from switch");
	a_held_run: assert property (cnt_reg == 4'hf |-> $stable(NODE_ADDR) && $stable(BIT_RATE)
		&& $stable(AUTOBAUD_EN) && $stable(TERM_EN))
		else $error("settings changed during run");
	a_link_refuse: assert property (acc && PADDR == node_cfg_pkg::LINK_OFFS
		&& (PWDATA[2:1] == 2'h3 || (cnt_reg == 4'hf && SW_PINS.rate != 2'h3)) |-> PSLVERR)
		else $error("link write not refused");
	a_commit_store: assert property (commit |-> !PSLVERR ##[1:2] NV_WE)
		else $error("commit not stored");
endmodule : node_cfg_chk
bind fieldbus_node_config node_cfg_chk #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_chk (
	.MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SW_PINS(SW_PINS),
	.NV_IN(NV_IN), .NV_WE(NV_WE), .NODE_ADDR(NODE_ADDR), .BIT_RATE(BIT_RATE),
	.AUTOBAUD_EN(AUTOBAUD_EN), .TERM_EN(TERM_EN));
`default_nettype wire

// ==== nv_store_model.sv ====
/* far-side model: the non-volatile store behind the configuration block.
 * assumes the write strobe is a one-cycle pulse on the same clock. */
`default_nettype none
module nv_store_model #(
	parameter node_cfg_pkg::nv_type INIT = '0
) (
	input wire logic clk,
	input wire logic we,
	input wire node_cfg_pkg::nv_type din,
	output node_cfg_pkg::nv_type dout
);
	timeunit 1ns;
	timeprecision 100ps;
	node_cfg_pkg::nv_type image_reg = INIT;
	assign dout = image_reg;
	// no reset: the image must outlive every power cycle
	always @(posedge clk) begin
		if (we)
			image_reg <= din;
	end
endmodule : nv_store_model
`default_nettype wire

// ==== fieldbus_node_config_test.sv ====
/* self-checking bench for the node configuration block with a store model.
 * assumes zero or more wait states on the register bus and a short flash divider. */
`default_nettype none
module fieldbus_node_config_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam node_cfg_pkg::nv_type NV0 = '{1'b0, 2'h1, 32'h5a5a0f0f};
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] cur = 32'h0;
	logic [31:0] prdata, rd, n_req;
	logic pready, pslverr, nv_we, term_en, gw_led, ios_led, irq, ab_en, e, ab, n_ab, old_t;
	logic [5:0] node_addr, old_a;
	logic [1:0] bit_rate, r, eff, n_rate;
	node_cfg_pkg::switch_type sw = '0;
	node_cfg_pkg::nv_type nv_in, nv_out;
	int err_total = 0;
	int comparisons = 0;
	int seed = 32'h3dbe;
	int m_act, m_tmp, m_req, m_irq, lo;
	always #2.5 mclk = ~mclk;
	fieldbus_node_config #(.FLASH_HALF_CYC(4)) i_dut (.MCLK(mclk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SW_PINS(sw), .CUR_CFG(cur), .NV_IN(nv_in),
		.NV_OUT(nv_out), .NV_WE(nv_we), .NODE_ADDR(node_addr), .BIT_RATE(bit_rate),
		.AUTOBAUD_EN(ab_en), .TERM_EN(term_en), .GW_LED(gw_led), .IOS_LED(ios_led), .IRQ(irq));
	nv_store_model #(.INIT(NV0)) i_nv (.clk(mclk), .we(nv_we), .din(nv_out), .dout(nv_in));
	task automatic summarize();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		e = pslverr;
		if (n >= 64)
			err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rchk
	// counts low samples of one indicator over three flash half periods
	task automatic blink(input logic gw, input logic exp);
		lo = 0;
		repeat (12) begin
			@(posedge mclk);
			if ((gw ? gw_led : ios_led) === 1'b0)
				lo++;
		end
		chk(gw ? "gw flash" : "ios flash", lo != 0, exp);
	endtask : blink
	task automatic power(input logic [1:0] rate);
		rst <= 1'b1;
		sw.rate <= rate;
		sw.addr <= 6'($random(seed));
		sw.term <= 1'($random(seed));
		cyc(16);
		rst <= 1'b0;
		cyc(20);
		m_act = n_req;
		m_tmp = n_req;
		m_req = n_req;
		m_irq = 0;
	endtask : power
	initial begin
		cyc(20000);
		err_total++;
		summarize();
	end
	initial begin
		n_rate = 2'h1;
		n_ab = 1'b0;
		n_req = 32'h5a5a0f0f;
		for (int i = 0; i < 5; i++) begin
			r = (i < 2) ? 2'h3 : 2'(i - 2);
			power(r);
			eff = (r == 2'h3) ? n_rate : r;
			ab = (r == 2'h3) && n_ab;
			chk("address", node_addr, sw.addr);
			chk("rate", bit_rate, eff);
			chk("autobaud", ab_en, ab);
			chk("term", term_en, sw.term);
			rchk(node_cfg_pkg::STAT_OFFS, {20'h0, sw.term, ab, eff, r, sw.addr}, "status");
			apb(1'b1, node_cfg_pkg::LINK_OFFS, 32'h6);
			chk("link code 3", e, 1'b1);
			apb(1'b1, node_cfg_pkg::LINK_OFFS, 32'h5);
			chk("link write", e, r != 2'h3);
			if (r == 2'h3) begin
				n_rate = 2'h2;
				n_ab = 1'b1;
			end
			rchk(node_cfg_pkg::LINK_OFFS, {29'h0, n_rate, n_ab}, "link pending");
			m_irq = 16;
			cyc(4);
			chk("rate held", bit_rate, eff);
		end
		chk("irq masked", irq, 1'b0);
		apb(1'b1, node_cfg_pkg::IRQ_MASK_OFFS, 32'h1f);
		cyc(2);
		chk("irq raised", irq, 1'b1);
		rchk(node_cfg_pkg::IRQ_MASK_OFFS, 32'h1f, "irq mask");
		rchk(8'h24, 32'h0, "unmapped data");
		chk("unmapped err", e, 1'b1);
		apb(1'b1, node_cfg_pkg::CMD_OFFS, 32'h7);
		chk("bad command", e, 1'b1);
		old_a = sw.addr;
		old_t = sw.term;
		sw.addr <= ~sw.addr;
		sw.term <= ~sw.term;
		cyc(10);
		chk("address held", node_addr, old_a);
		chk("term held", term_en, old_t);
		m_tmp = $random(seed);
		apb(1'b1, node_cfg_pkg::TEMP_OFFS, m_tmp);
		rchk(node_cfg_pkg::REQ_OFFS, m_req, "required kept");
		rchk(node_cfg_pkg::STAT_OFFS, {19'h0, 1'b1, old_t, ab, eff, r, old_a}, "mismatch");
		blink(1'b0, 1'b1);
		apb(1'b1, node_cfg_pkg::CMD_OFFS, node_cfg_pkg::CMD_COMMIT);
		m_req = m_tmp;
		n_req = m_req;
		m_irq |= 2;
		rchk(node_cfg_pkg::REQ_OFFS, m_req, "commit");
		apb(1'b1, node_cfg_pkg::TEMP_OFFS, $random(seed));
		apb(1'b1, node_cfg_pkg::CMD_OFFS, node_cfg_pkg::CMD_RESTORE);
		m_tmp = m_req;
		m_irq |= 8;
		rchk(node_cfg_pkg::TEMP_OFFS, m_tmp, "restore");
		apb(1'b1, node_cfg_pkg::TEMP_OFFS, $random(seed));
		apb(1'b1, node_cfg_pkg::CMD_OFFS, node_cfg_pkg::CMD_LOAD_CURRENT);
		m_tmp = m_act;
		m_req = m_act;
		n_req = m_act;
		m_irq |= 4;
		rchk(node_cfg_pkg::TEMP_OFFS, m_tmp, "load temp");
		rchk(node_cfg_pkg::REQ_OFFS, m_req, "load required");
		blink(1'b0, 1'b0);
		cur <= $random(seed);
		cyc(2);
		rchk(node_cfg_pkg::CURRENT_OFFS, cur, "current");
		// operator sequence off, on, off with settle time around each step
		sw.save <= 1'b1;
		cyc(6);
		sw.save <= 1'b0;
		cyc(6);
		m_act = cur;
		m_tmp = cur;
		m_req = cur;
		n_req = cur;
		m_irq |= 1;
		blink(1'b1, 1'b1);
		rchk(node_cfg_pkg::ACTUAL_OFFS, m_act, "save actual");
		rchk(node_cfg_pkg::TEMP_OFFS, m_tmp, "save temp");
		rchk(node_cfg_pkg::REQ_OFFS, m_req, "save required");
		rchk(node_cfg_pkg::IRQ_STAT_OFFS, m_irq, "irq status");
		apb(1'b1, node_cfg_pkg::IRQ_STAT_OFFS, m_irq);
		rchk(node_cfg_pkg::IRQ_STAT_OFFS, 32'h0, "irq cleared");
		cyc(2);
		chk("irq low", irq, 1'b0);
		power(2'h2);
		rchk(node_cfg_pkg::REQ_OFFS, n_req, "stored required");
		rchk(node_cfg_pkg::ACTUAL_OFFS, n_req, "stored actual");
		summarize();
	end
endmodule : fieldbus_node_config_test
`default_nettype wire
